// file: shared/sadc_map.svh
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
// ****************************************
// Widths and timing
// ****************************************
`define SADC_RES_BITS 12
`define SADC_CLK_SYS_NS 100
// Sample window in half shift-clock periods (1.5 periods)
`define SADC_SAMPLE_HALVES 3
`define SADC_CONVERT_PERIODS 12
`define SADC_SELECT_ACTIVE_PERIODS 14
// Select idle time between transfers, in ns (5.0 us)
`define SADC_SELECT_IDLE_NS 5000
`define SADC_SELECT_IDLE_CYC ((`SADC_SELECT_IDLE_NS + `SADC_CLK_SYS_NS - 1) / `SADC_CLK_SYS_NS)
// Shift clock half period of the host, in system cycles
`define SADC_HALF_PERIOD_CYC 8
// Throughput limit in Hz (30 kHz)
`define SADC_MAX_RATE_HZ 30000
`define SADC_SEQ_BITS 24
`endif

// file: shared/sadc_pkg.sv
package sadc_pkg;
  typedef logic [11:0] sadc_code_type;
  typedef enum logic [3:0] {
    SADC_IDLE = 4'b0001,
    SADC_SAMPLE = 4'b0010,
    SADC_CONVERT = 4'b0100,
    SADC_SHIFT = 4'b1000
  } sadc_dev_state_type;
  typedef enum logic [2:0] {
    SADC_H_IDLE = 3'b001,
    SADC_H_XFER = 3'b010,
    SADC_H_GAP = 3'b100
  } sadc_host_state_type;
endpackage : sadc_pkg

// file: shared/sadc_link_if.sv
`timescale 1ns/1ps
interface sadc_link_if;
  logic select_n;
  logic shift_clk;
  logic result_data;
  logic result_oe;
  modport dev (input select_n, input shift_clk, output result_data, output result_oe);
  modport host (output select_n, output shift_clk, input result_data, input result_oe);
endinterface : sadc_link_if

// file: src/sadc_device.sv
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_device import sadc_pkg::*; (
  // System
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Analog front end, already digitised levels
  input wire logic [11:0] ain_pos_in,
  input wire logic [11:0] ain_neg_in,
  // Link
  sadc_link_if.dev link,
  // Status
  output logic busy_out,
  output logic [11:0] last_code_out
);
  // ****************************************
  // Link edge detection
  // ****************************************
  logic clk_q;
  logic fall;
  logic rise;
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= link.shift_clk;
    end
  end
  assign fall = clk_q && !link.shift_clk;
  assign rise = !clk_q && link.shift_clk;

  // ****************************************
  // Sequencer
  // ****************************************
  sadc_dev_state_type state_q;
  logic [4:0] half_q;
  logic [3:0] bit_q;
  logic [11:0] held_q;
  logic [11:0] sar_q;
  logic [11:0] code_q;
  logic [4:0] out_idx_q;
  logic oe_q;
  logic dat_q;
  logic [11:0] trial;
  logic keep_trial;
  logic last_trial;
  logic [11:0] final_code;
  logic [11:0] cur_code;
  assign trial = sar_q | (12'h800 >> bit_q);
  assign keep_trial = (trial <= held_q);
  assign last_trial = (state_q == SADC_CONVERT) && fall && (bit_q == 4'(`SADC_CONVERT_PERIODS - 1));
  assign final_code = keep_trial ? trial : sar_q;

  // Select high parks the machine, so every transfer starts from idle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || link.select_n) begin
      state_q <= SADC_IDLE;
    end else begin
      case (state_q)
        SADC_IDLE: begin
          // No dead time after select falls keeps back-to-back transfers at full rate
          state_q <= SADC_SAMPLE;
        end
        SADC_SAMPLE: begin
          if ((rise || fall) && half_q == 5'(`SADC_SAMPLE_HALVES - 1)) begin
            state_q <= SADC_CONVERT;
          end
        end
        SADC_CONVERT: begin
          if (last_trial) begin
            state_q <= SADC_SHIFT;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ****************************************
  // Sample and conversion
  // ****************************************

  // Sample window counts both shift clock edges, in half periods
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || link.select_n) begin
      half_q <= 5'h00;
    end else if (state_q == SADC_SAMPLE && (rise || fall)) begin
      half_q <= half_q + 5'h01;
    end
  end

  // One trial bit per falling edge during conversion
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || link.select_n) begin
      bit_q <= 4'h0;
    end else if (state_q == SADC_CONVERT && fall) begin
      bit_q <= bit_q + 4'h1;
    end
  end

  // Keep the trial bit while the trial value still fits the held sample
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || link.select_n) begin
      sar_q <= 12'h000;
    end else if (state_q == SADC_CONVERT && fall && keep_trial) begin
      sar_q <= trial;
    end
  end

  // Held sample: difference of inputs, clamped for unipolar mode
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      held_q <= 12'h000;
    end else if (state_q == SADC_SAMPLE) begin
      held_q <= (ain_pos_in > ain_neg_in) ? (ain_pos_in - ain_neg_in) : 12'h000;
    end
  end

  // Final code, shifted out during the transfer
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      code_q <= 12'h000;
    end else if (last_trial) begin
      code_q <= final_code;
    end
  end

  // ****************************************
  // Code view for the shifter
  // ****************************************

  // The bit decided on this falling edge is already in place, so each
  // result bit can leave on the very edge that decides it.
  always_comb begin
    cur_code = code_q;
    if (state_q == SADC_CONVERT) begin
      cur_code = sar_q | (keep_trial ? (12'h800 >> bit_q) : 12'h000);
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  // Output index counts falling edges since select fell; the first enables
  // the driver with the null bit, result bits follow on later falls.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || link.select_n) begin
      oe_q <= 1'b0;
      out_idx_q <= 5'h00;
    end else if (fall) begin
      oe_q <= 1'b1;
      if (out_idx_q != 5'h1f) begin
        out_idx_q <= out_idx_q + 5'h01;
      end
    end
  end

  // Null bit, MSB first, LSB first sharing the LSB, then zeros
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || link.select_n) begin
      dat_q <= 1'b0;
    end else if (fall) begin
      if (out_idx_q == 5'h00) begin
        dat_q <= 1'b0;
      end else if (out_idx_q <= 5'(`SADC_RES_BITS)) begin
        dat_q <= cur_code[4'(5'(`SADC_RES_BITS) - out_idx_q)];
      end else if (out_idx_q < 5'(`SADC_SEQ_BITS)) begin
        dat_q <= cur_code[4'(out_idx_q - 5'(`SADC_RES_BITS))];
      end else begin
        dat_q <= 1'b0;
      end
    end
  end

  assign link.result_data = dat_q;
  assign link.result_oe = oe_q;

  // ****************************************
  // Status
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      busy_out <= 1'b0;
      last_code_out <= 12'h000;
    end else begin
      busy_out <= !link.select_n;
      if (last_trial) begin
        last_code_out <= final_code;
      end
    end
  end
endmodule : sadc_device

// file: src/sadc_host.sv
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_host import sadc_pkg::*; (
  // System
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // User side
  input wire logic start_in,
  output logic ready_out,
  output logic done_out,
  output logic [11:0] msb_code_out,
  output logic [11:0] lsb_code_out,
  output logic match_out,
  // Link
  sadc_link_if.host link
);
  sadc_host_state_type state_q;
  logic sel_n_q;
  logic sclk_q;
  logic [3:0] div_q;
  logic [4:0] rise_q;
  logic [7:0] gap_q;
  logic [23:0] sh_q;
  logic [11:0] rev;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      rev[i] = sh_q[11 - i];
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_q <= SADC_H_GAP;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b0;
      div_q <= 4'h0;
      rise_q <= 5'h00;
      gap_q <= 8'h00;
      sh_q <= 24'h000000;
      done_out <= 1'b0;
      ready_out <= 1'b0;
      msb_code_out <= 12'h000;
      lsb_code_out <= 12'h000;
      match_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        SADC_H_IDLE: begin
          ready_out <= 1'b1;
          if (start_in) begin
            sel_n_q <= 1'b0;
            ready_out <= 1'b0;
            div_q <= 4'h0;
            rise_q <= 5'h00;
            state_q <= SADC_H_XFER;
          end
        end
        SADC_H_XFER: begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'(`SADC_HALF_PERIOD_CYC - 1)) begin
            div_q <= 4'h0;
            sclk_q <= !sclk_q;
            if (!sclk_q) begin
              // Rising edge: sample the output
              rise_q <= rise_q + 5'h01;
              if (rise_q >= 5'h02 && rise_q < 5'h19) begin
                sh_q <= {sh_q[22:0], link.result_data};
              end
            end else if (rise_q == 5'h19) begin
              // 25 periods, beyond the 14 minimum
              sel_n_q <= 1'b1;
              gap_q <= 8'h00;
              state_q <= SADC_H_GAP;
              msb_code_out <= sh_q[22:11];
              lsb_code_out <= rev;
              match_out <= (sh_q[22:11] == rev);
              done_out <= 1'b1;
            end
          end
        end
        default: begin
          gap_q <= gap_q + 8'h01;
          if (gap_q == 8'(`SADC_SELECT_IDLE_CYC - 1)) begin
            state_q <= SADC_H_IDLE;
          end
        end
      endcase
    end
  end
  assign link.select_n = sel_n_q;
  assign link.shift_clk = sclk_q;
endmodule : sadc_host

// file: dv/sadc_link_checker.sv
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_link_checker (
  // System
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Link
  input wire logic select_n_in,
  input wire logic shift_clk_in,
  input wire logic result_data_in,
  input wire logic result_oe_in
);
  // ****************************************
  // Helper counters
  // ****************************************
  int unsigned hi_q;
  int unsigned rise_q;
  logic clk_q;
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || !select_n_in) begin
      hi_q <= 0;
    end else begin
      hi_q <= hi_q + 1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    clk_q <= shift_clk_in;
    if (!nrst_in || select_n_in) begin
      rise_q <= 0;
    end else begin
      rise_q <= rise_q + 32'(shift_clk_in & ~clk_q);
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // ****************************************
  // Link assertions
  // ****************************************
  chk_hiz_on_rise: assert property ($rose(select_n_in) |-> ##[0:2] !result_oe_in)
    else $error("output still driven after select rose");
  chk_idle_undriven: assert property (select_n_in [*3] |-> !result_oe_in)
    else $error("output driven while select high");
  chk_enable_after_fall: assert property ($rose(result_oe_in) |-> !shift_clk_in && !select_n_in)
    else $error("output enabled outside a low clock phase");
  chk_data_on_fall: assert property (result_oe_in && $past(result_oe_in) && $changed(result_data_in)
    |-> !shift_clk_in)
    else $error("data changed while shift clock high");
  chk_select_gap: assert property ($fell(select_n_in) |-> hi_q >= `SADC_SELECT_IDLE_CYC)
    else $error("select idle time too short");
  chk_select_len: assert property ($rose(select_n_in) |-> rise_q >= 14)
    else $error("select low for too few clock periods");
  chk_setup_first: assert property ($fell(select_n_in) |-> !shift_clk_in ##1 !shift_clk_in)
    else $error("shift clock high at select fall");
  chk_half_period: assert property ($rose(shift_clk_in) |-> shift_clk_in [*8] ##1 !shift_clk_in)
    else $error("shift clock high phase wrong");
endmodule : sadc_link_checker

// file: dv/tb.sv
`timescale 1ns/1ps
module tb import sadc_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic start_in = 1'b0;
  sadc_code_type ain_pos_in = 12'h000;
  sadc_code_type ain_neg_in = 12'h000;
  logic ready_out, done_out, match_out, busy_out;
  sadc_code_type msb_code_out, lsb_code_out, last_code_out;
  logic [23:0] wire_q = 24'h000000;
  int errors = 0;
  int checks = 0;
  sadc_link_if link ();
  sadc_device u_sadc_device (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ain_pos_in(ain_pos_in),
    .ain_neg_in(ain_neg_in), .link(link.dev), .busy_out(busy_out), .last_code_out(last_code_out));
  sadc_host u_sadc_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .start_in(start_in),
    .ready_out(ready_out), .done_out(done_out), .msb_code_out(msb_code_out),
    .lsb_code_out(lsb_code_out), .match_out(match_out), .link(link.host));
  sadc_link_checker u_sadc_link_checker (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .select_n_in(link.select_n), .shift_clk_in(link.shift_clk), .result_data_in(link.result_data),
    .result_oe_in(link.result_oe));
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Bits seen by the host on each rising shift clock edge while driven
  always @(posedge link.shift_clk) begin
    if (link.select_n === 1'b0 && link.result_oe === 1'b1) wire_q = {wire_q[22:0], link.result_data};
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  function automatic logic [23:0] wire_exp(input sadc_code_type c);
    logic [23:0] w;
    w = {1'b0, c, 11'h000};
    for (int k = 1; k < 12; k++) w[11-k] = c[k];
    return w;
  endfunction : wire_exp
  task automatic run_one(input sadc_code_type p, input sadc_code_type n);
    sadc_code_type e;
    int i;
    e = (p >= n) ? p - n : 12'h000;
    ain_pos_in = p;
    ain_neg_in = n;
    for (i = 0; i < 2000 && ready_out !== 1'b1; i++) @(negedge clk_sys_in);
    if (i == 2000) begin
      errors++;
      finish_test();
    end
    start_in = 1'b1;
    for (i = 0; i < 2000 && done_out !== 1'b1; i++) @(negedge clk_sys_in);
    start_in = 1'b0;
    if (i == 2000) begin
      errors++;
      finish_test();
    end
    check(24'(msb_code_out), 24'(e));
    check(24'(lsb_code_out), 24'(e));
    check(24'(match_out), 24'h000001);
    check(24'(last_code_out), 24'(e));
    check(wire_q, wire_exp(e));
    check(24'(busy_out), 24'h000001);
    @(negedge clk_sys_in);
    check(24'(busy_out), 24'h000000);
  endtask : run_one
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_codes();
    sadc_code_type tp [4] = '{12'ha5c, 12'hfff, 12'h123, 12'h801};
    sadc_code_type tn [4] = '{12'h000, 12'h000, 12'h124, 12'h800};
    for (int t = 0; t < 4; t++) run_one(tp[t], tn[t]);
    $display("test_codes done");
  endtask : test_codes
  task automatic test_back_to_back();
    run_one(12'h001, 12'h000);
    run_one(12'hffe, 12'h000);
    $display("test_back_to_back done");
  endtask : test_back_to_back
  task automatic test_reset_mid();
    ain_pos_in = 12'h555;
    start_in = 1'b1;
    repeat (150) @(negedge clk_sys_in);
    check(24'(busy_out), 24'h000001);
    start_in = 1'b0;
    nrst_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    check(24'(link.result_oe), 24'h000000);
    check(24'(link.select_n), 24'h000001);
    nrst_in = 1'b1;
    run_one(12'h3c7, 12'h0c7);
    $display("test_reset_mid done");
  endtask : test_reset_mid
  initial begin
    repeat (4) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    test_codes();
    test_back_to_back();
    test_reset_mid();
    finish_test();
  end
endmodule : tb
